// ### src/ppa_consts.svh
/*
 * Command codes, field positions, reset values and bus addresses of the
 * paging, write-protect and addressing command layer.
 * Assumes it is included by bare name from the design module.
 */
`ifndef PPA_CONSTS_SVH
`define PPA_CONSTS_SVH

// ****************************************************************************
// Command codes held in this block
// ****************************************************************************
`define PPA_CMD_PAGE 8'h00
`define PPA_CMD_PAGE_PLUS_WRITE 8'h05
`define PPA_CMD_PAGE_PLUS_READ 8'h06
`define PPA_CMD_WRITE_LOCK 8'h10
`define PPA_CMD_CHAN_CONFIG 8'hd0
`define PPA_CMD_GLOBAL_CONFIG 8'hd1
`define PPA_CMD_DEV_ADDR 8'he6
`define PPA_CMD_RAIL_ADDR 8'hfa

// ****************************************************************************
// Command codes handled downstream and checked against the write lock
// ****************************************************************************
`define PPA_CMD_OPERATION 8'h01
`define PPA_CMD_ON_OFF_CONFIG 8'h02
`define PPA_CMD_CLEAR_FAULTS 8'h03
`define PPA_CMD_STORE_ALL 8'h15
`define PPA_CMD_VOUT_SETPOINT 8'h21
`define PPA_CMD_STATUS_FIRST 8'h78
`define PPA_CMD_STATUS_LAST 8'h80
`define PPA_CMD_NV_UNLOCK 8'hbd
`define PPA_CMD_PEAK_CLEAR 8'he3

// ****************************************************************************
// Register values and fields
// ****************************************************************************
`define PPA_PAGE_CH0 8'h00
`define PPA_PAGE_CH1 8'h01
`define PPA_PAGE_BOTH 8'hff
`define PPA_LOCK_NONE 8'h00
`define PPA_LOCK_LEVEL_20 8'h20
`define PPA_LOCK_LEVEL_40 8'h40
`define PPA_LOCK_LEVEL_80 8'h80
`define PPA_ADDR_DISABLE_BIT 7
`define PPA_ADDR_LOW_WIDTH 4
`define PPA_ADDR_HIGH_WIDTH 3

// ****************************************************************************
// Reset values and global addresses
// ****************************************************************************
`define PPA_RST_PAGE 8'h00
`define PPA_RST_WRITE_LOCK 8'h00
`define PPA_RST_CHAN_CONFIG 8'h1d
`define PPA_RST_GLOBAL_CONFIG 8'h21
`define PPA_RST_DEV_ADDR 8'h4f
`define PPA_RST_RAIL_ADDR 8'h80
`define PPA_GLOBAL_ADDR_A 7'h5a
`define PPA_GLOBAL_ADDR_B 7'h5b

`endif

// ### src/ppa_pkg.sv
/*
 * Types shared by the paging, write-protect and addressing command layer.
 */
package ppa_pkg;

  typedef logic [7:0] ppa_byte_t;

  typedef logic [1:0] ppa_chan_mask_t;

  // Kind of packet seen at the command layer.
  typedef enum logic [1:0] {
    PPA_KIND_PLAIN = 2'b00,
    PPA_KIND_PP_WRITE = 2'b01,
    PPA_KIND_PP_READ = 2'b10
  } ppa_kind_t;

endpackage : ppa_pkg

// ### src/ppa_top.sv
/*
 * Command layer of a dual-channel power controller's management port: channel
 * paging, page-plus write and read, write-lock levels, write-protect pin gating,
 * device, global and rail bus addresses, and rail-read contention.
 * Assumes a protocol layer that delivers each decoded packet as a one-cycle request
 * and turns the registered answer into ACK/NACK and read bytes, and an NV loader
 * that pulses nv_load once after reset with the stored values.
 */
`timescale 1ns/1ps

`include "ppa_consts.svh"

module ppa_top
  import ppa_pkg::*;
(
  input wire logic sys_clk, // 20 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic nv_load, // Pulse: load stored values below
  input wire logic [7:0] nv_write_lock, // Stored write-lock level
  input wire logic [7:0] nv_chan_cfg0, // Stored channel 0 config
  input wire logic [7:0] nv_chan_cfg1, // Stored channel 1 config
  input wire logic [7:0] nv_global_cfg, // Stored global config
  input wire logic [7:0] nv_dev_addr, // Stored device address
  input wire logic [7:0] nv_rail0, // Stored channel 0 rail address
  input wire logic [7:0] nv_rail1, // Stored channel 1 rail address
  input wire logic addr_select_low_open, // Low select pin left open
  input wire logic [3:0] addr_select_low_val, // Low select pin decoded value
  input wire logic addr_select_high_open, // High select pin left open
  input wire logic [2:0] addr_select_high_val, // High select pin decoded value
  input wire logic wp_pin, // Write-protect pin, high protects
  input wire logic req_valid, // Pulse: one decoded packet
  input wire logic [6:0] req_addr, // Slave address of the packet
  input wire logic req_read, // Plain packet is a read
  input wire logic [7:0] req_code, // Outer command code
  input wire logic [7:0] req_pp_page, // Page byte of a page-plus packet
  input wire logic [7:0] req_pp_code, // Inner code of a page-plus packet
  input wire logic [7:0] req_wdata, // Write data byte
  input wire logic rail_contention, // Pulse: read byte differed on the bus
  input wire logic [7:0] ext_rdata0, // Downstream read data, channel 0
  input wire logic [7:0] ext_rdata1, // Downstream read data, channel 1
  output logic rsp_valid, // Pulse: answer to the last request
  output logic rsp_ack, // Packet accepted
  output logic [7:0] rsp_rdata, // Read data byte
  output logic [1:0] fwd_wr_en, // Pulse: per-channel downstream write
  output logic [7:0] fwd_code, // Downstream command code
  output logic [7:0] fwd_data, // Downstream write data
  output logic [1:0] fwd_rd_sel, // Channel read, for the downstream mux
  output logic cml_fault, // Pulse: communication fault
  output logic [7:0] page_out, // Current page selector
  output logic [7:0] global_cfg_out, // Current global config bits
  output logic [6:0] effective_addr, // Effective individual address
  output logic wp_status // Pin state for the common status byte
);

  // **************************************************************************
  // Registers
  // **************************************************************************
  ppa_byte_t page;
  ppa_byte_t write_lock;
  ppa_byte_t global_cfg;
  ppa_byte_t dev_addr;
  ppa_byte_t chan_cfg [2];
  ppa_byte_t rail_addr [2];
  logic rail_read_open;

  // **************************************************************************
  // Command classification
  // **************************************************************************
  function automatic logic is_status(input ppa_byte_t c);
    is_status = (c >= `PPA_CMD_STATUS_FIRST) && (c <= `PPA_CMD_STATUS_LAST);
  endfunction : is_status

  function automatic logic is_paged(input ppa_byte_t c);
    is_paged = (c == `PPA_CMD_OPERATION) || (c == `PPA_CMD_ON_OFF_CONFIG) ||
               (c == `PPA_CMD_VOUT_SETPOINT) || (c == `PPA_CMD_CHAN_CONFIG) ||
               (c == `PPA_CMD_RAIL_ADDR) || is_status(c);
  endfunction : is_paged

  // Write permission from the lock level and the protect pin.
  function automatic logic write_allowed(input ppa_byte_t c, input ppa_byte_t lvl,
                                         input logic pin);
    logic base;
    logic mid;
    logic low;
    logic lvl_ok;
    logic pin_ok;
    base = (c == `PPA_CMD_WRITE_LOCK) || (c == `PPA_CMD_PAGE) ||
           (c == `PPA_CMD_NV_UNLOCK) || (c == `PPA_CMD_STORE_ALL);
    mid = base || (c == `PPA_CMD_PEAK_CLEAR) || (c == `PPA_CMD_OPERATION) ||
          (c == `PPA_CMD_CLEAR_FAULTS) || is_status(c);
    low = mid || (c == `PPA_CMD_ON_OFF_CONFIG) || (c == `PPA_CMD_VOUT_SETPOINT);
    case (lvl)
      `PPA_LOCK_NONE: lvl_ok = 1'b1;
      `PPA_LOCK_LEVEL_80: lvl_ok = base;
      `PPA_LOCK_LEVEL_40: lvl_ok = mid;
      `PPA_LOCK_LEVEL_20: lvl_ok = low;
      default: lvl_ok = base;
    endcase
    pin_ok = (c == `PPA_CMD_PAGE) || (c == `PPA_CMD_OPERATION) ||
             (c == `PPA_CMD_PEAK_CLEAR) || (c == `PPA_CMD_NV_UNLOCK) ||
             (c == `PPA_CMD_WRITE_LOCK) || (c == `PPA_CMD_CLEAR_FAULTS) ||
             is_status(c);
    write_allowed = lvl_ok && (!pin || pin_ok);
  endfunction : write_allowed

  // **************************************************************************
  // Address decode
  // **************************************************************************
  logic dev_hit;
  logic glob_hit;
  logic [1:0] rail_hit;
  logic addr_hit;

  always_comb begin
    effective_addr[3:0] = addr_select_low_open ? dev_addr[3:0] : addr_select_low_val;
    effective_addr[6:4] = addr_select_high_open ? dev_addr[6:4] : addr_select_high_val;
  end // both open gives the stored value unchanged.

  assign dev_hit = !dev_addr[`PPA_ADDR_DISABLE_BIT] && (req_addr == effective_addr);
  assign glob_hit = (req_addr == `PPA_GLOBAL_ADDR_A) || (req_addr == `PPA_GLOBAL_ADDR_B);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_rail
      assign rail_hit[gi] = !rail_addr[gi][`PPA_ADDR_DISABLE_BIT] &&
                            (req_addr == rail_addr[gi][6:0]);
    end
  endgenerate

  assign addr_hit = dev_hit || glob_hit || (|rail_hit);
  assign wp_status = wp_pin;

  // **************************************************************************
  // Request decode
  // **************************************************************************
  ppa_kind_t kind;
  ppa_byte_t tcode;
  ppa_byte_t sel_page;
  ppa_chan_mask_t mask;
  logic is_rd;
  logic nested;
  logic bad_page;
  logic bad_value;
  logic allowed;
  logic accept;
  logic refuse;
  logic local_cmd;
  logic rd_ch1;
  ppa_byte_t rd_byte;

  always_comb begin
    case (req_code)
      `PPA_CMD_PAGE_PLUS_WRITE: kind = PPA_KIND_PP_WRITE;
      `PPA_CMD_PAGE_PLUS_READ: kind = PPA_KIND_PP_READ;
      default: kind = PPA_KIND_PLAIN;
    endcase
  end

  always_comb begin
    tcode = (kind == PPA_KIND_PLAIN) ? req_code : req_pp_code;
    sel_page = (kind == PPA_KIND_PLAIN) ? page : req_pp_page;
    is_rd = (kind == PPA_KIND_PP_READ) || ((kind == PPA_KIND_PLAIN) && req_read);
    nested = (kind != PPA_KIND_PLAIN) && ((req_pp_code == `PPA_CMD_PAGE_PLUS_WRITE) ||
                                          (req_pp_code == `PPA_CMD_PAGE_PLUS_READ));
    if (|rail_hit && !dev_hit && !glob_hit) begin
      mask = rail_hit;
    end else begin
      case (sel_page)
        `PPA_PAGE_CH0: mask = 2'b01;
        `PPA_PAGE_CH1: mask = 2'b10;
        `PPA_PAGE_BOTH: mask = 2'b11;
        default: mask = 2'b00;
      endcase
    end
    // A non-paged target is never refused for a bad page byte; the page still picks the read channel.
    bad_page = is_paged(tcode) && (mask == 2'b00);
    bad_value = 1'b0;
    if (!is_rd && (tcode == `PPA_CMD_PAGE)) begin
      bad_value = (req_wdata != `PPA_PAGE_CH0) && (req_wdata != `PPA_PAGE_CH1) &&
                  (req_wdata != `PPA_PAGE_BOTH);
    end else if (!is_rd && (tcode == `PPA_CMD_WRITE_LOCK)) begin
      bad_value = (req_wdata != `PPA_LOCK_NONE) && (req_wdata != `PPA_LOCK_LEVEL_20) &&
                  (req_wdata != `PPA_LOCK_LEVEL_40) && (req_wdata != `PPA_LOCK_LEVEL_80);
    end
    allowed = is_rd || write_allowed(tcode, write_lock, wp_pin);
    accept = req_valid && addr_hit && !nested && !bad_page && !bad_value && allowed;
    refuse = req_valid && addr_hit && !accept;
    local_cmd = (tcode == `PPA_CMD_PAGE) || (tcode == `PPA_CMD_WRITE_LOCK) ||
                (tcode == `PPA_CMD_CHAN_CONFIG) || (tcode == `PPA_CMD_GLOBAL_CONFIG) ||
                (tcode == `PPA_CMD_DEV_ADDR) || (tcode == `PPA_CMD_RAIL_ADDR);
    // Reads with both pages selected come from channel 0.
    rd_ch1 = (mask == 2'b10);
    case (tcode)
      `PPA_CMD_PAGE: rd_byte = page;
      `PPA_CMD_WRITE_LOCK: rd_byte = write_lock;
      `PPA_CMD_CHAN_CONFIG: rd_byte = chan_cfg[rd_ch1];
      `PPA_CMD_GLOBAL_CONFIG: rd_byte = global_cfg;
      `PPA_CMD_DEV_ADDR: rd_byte = dev_addr;
      `PPA_CMD_RAIL_ADDR: rd_byte = rail_addr[rd_ch1];
      default: rd_byte = rd_ch1 ? ext_rdata1 : ext_rdata0;
    endcase
  end

  assign fwd_rd_sel = rd_ch1 ? 2'b10 : 2'b01;

  // **************************************************************************
  // Stored registers
  // **************************************************************************
  logic do_write;
  assign do_write = accept && !is_rd;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      page <= `PPA_RST_PAGE;
    end else if (do_write && (tcode == `PPA_CMD_PAGE)) begin
      page <= req_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      write_lock <= `PPA_RST_WRITE_LOCK;
      global_cfg <= `PPA_RST_GLOBAL_CONFIG;
      dev_addr <= `PPA_RST_DEV_ADDR;
    end else if (nv_load) begin
      write_lock <= nv_write_lock;
      global_cfg <= nv_global_cfg;
      dev_addr <= nv_dev_addr;
    end else if (do_write) begin
      case (tcode)
        `PPA_CMD_WRITE_LOCK: write_lock <= req_wdata;
        `PPA_CMD_GLOBAL_CONFIG: global_cfg <= req_wdata;
        `PPA_CMD_DEV_ADDR: dev_addr <= req_wdata;
        default: dev_addr <= dev_addr;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        chan_cfg[i] <= `PPA_RST_CHAN_CONFIG;
        rail_addr[i] <= `PPA_RST_RAIL_ADDR;
      end
    end else if (nv_load) begin
      chan_cfg[0] <= nv_chan_cfg0;
      chan_cfg[1] <= nv_chan_cfg1;
      rail_addr[0] <= nv_rail0;
      rail_addr[1] <= nv_rail1;
    end else if (do_write) begin
      for (int i = 0; i < 2; i++) begin
        if (mask[i] && (tcode == `PPA_CMD_CHAN_CONFIG)) begin
          chan_cfg[i] <= req_wdata;
        end
        if (mask[i] && (tcode == `PPA_CMD_RAIL_ADDR)) begin
          rail_addr[i] <= req_wdata;
        end
      end
    end
  end

  // **************************************************************************
  // Answer and downstream write
  // **************************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_ack <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp_ack <= accept;
        rsp_rdata <= (accept && is_rd) ? rd_byte : 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fwd_wr_en <= 2'b00;
      fwd_code <= 8'h00;
      fwd_data <= 8'h00;
    end else begin
      fwd_wr_en <= 2'b00;
      if (do_write && !local_cmd) begin
        fwd_wr_en <= is_paged(tcode) ? mask : 2'b11;
        fwd_code <= tcode;
        fwd_data <= req_wdata;
      end
    end
  end

  // **************************************************************************
  // Communication fault and rail contention
  // **************************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rail_read_open <= 1'b0;
    end else if (req_valid) begin
      rail_read_open <= accept && is_rd && (|rail_hit) && !dev_hit && !glob_hit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cml_fault <= 1'b0;
    end else begin
      cml_fault <= refuse || (rail_read_open && rail_contention && !req_valid);
    end
  end

  assign page_out = page;
  assign global_cfg_out = global_cfg;

endmodule : ppa_top

// ### sim/ppa_top_asserts.sv
/*
 * Checker for the paging, write-lock and addressing command layer.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps

module ppa_top_chk
  import ppa_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic wp_pin, // Protect pin
  input wire logic req_valid, // Request
  input wire logic [6:0] req_addr, // Slave address
  input wire logic req_read, // Read
  input wire logic [7:0] req_code, // Outer code
  input wire logic [7:0] req_pp_code, // Inner code
  input wire logic [7:0] req_wdata, // Write data
  input wire logic addr_select_low_open, // Low pin open
  input wire logic [3:0] addr_select_low_val, // Low pin value
  input wire logic addr_select_high_open, // High pin open
  input wire logic [2:0] addr_select_high_val, // High pin value
  input wire logic rsp_valid, // Answer
  input wire logic rsp_ack, // Accepted
  input wire logic [1:0] fwd_wr_en, // Forward strobe
  input wire logic cml_fault, // Fault pulse
  input wire logic [7:0] page_out, // Page
  input wire logic [7:0] global_cfg_out, // Global config
  input wire logic [6:0] effective_addr, // Address
  input wire logic wp_status // Pin copy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_glob_req;
    req_valid && req_addr inside {7'h5a, 7'h5b};
  endsequence
  sequence s_nested;
    s_glob_req ##0 (req_code inside {8'h05, 8'h06} && req_pp_code inside {8'h05, 8'h06});
  endsequence
  sequence s_refused;
    rsp_valid && !rsp_ack && cml_fault && fwd_wr_en == 2'b00;
  endsequence

  a_rsp_timing: assert property (req_valid |=> rsp_valid)
    else $error("answer missing one cycle after request");
  a_nested_nack: assert property (s_nested |=> s_refused)
    else $error("nested page-plus not refused");
  a_wp_blocks: assert property (s_glob_req ##0 (wp_pin && !req_read &&
    req_code == 8'hd1) |=> s_refused ##0 global_cfg_out == $past(global_cfg_out))
    else $error("protected write not refused");
  a_page_write: assert property (s_glob_req ##0 (!req_read && req_code == 8'h00 &&
    req_wdata inside {8'h00, 8'h01, 8'hff}) |=> rsp_ack && page_out == $past(req_wdata))
    else $error("page write not stored");
  a_pp_page_kept: assert property (req_valid && req_code inside {8'h05, 8'h06}
    |=> page_out == $past(page_out))
    else $error("page-plus changed page");
  a_fault_quiet: assert property (cml_fault && rsp_valid |-> !rsp_ack && fwd_wr_en == 2'b00)
    else $error("faulted packet acked or forwarded");
  a_fwd_cause: assert property (fwd_wr_en != 2'b00 |-> rsp_valid && rsp_ack)
    else $error("forward without accepted answer");
  a_wp_mirror: assert property (wp_status == wp_pin)
    else $error("pin status differs from pin");
  a_pins_addr: assert property (!addr_select_low_open && !addr_select_high_open
    |-> effective_addr == {addr_select_high_val, addr_select_low_val})
    else $error("address not taken from pins");
  a_glob_ack: assert property (s_glob_req ##0 (req_read && req_code == 8'h10) |=> rsp_ack)
    else $error("global address not answered");
endmodule : ppa_top_chk

bind ppa_top ppa_top_chk u_chk (.*);

// ### sim/ppa_host.sv
/*
 * Host master model issuing one decoded packet at a time.
 * Assumes the bench calls send and samples the answer when it returns.
 */
`timescale 1ns/1ps

module ppa_host (
  input wire logic sys_clk, // Clock
  output logic req_valid, // Request
  output logic [6:0] req_addr, // Slave address
  output logic req_read, // Read
  output logic [7:0] req_code, // Outer code
  output logic [7:0] req_pp_page, // Page byte
  output logic [7:0] req_pp_code, // Inner code
  output logic [7:0] req_wdata // Write data
);
  initial begin
    {req_valid, req_addr, req_read, req_code, req_pp_page, req_pp_code, req_wdata} = '0;
  end

  // Released address, code, page and data lines show the inverse so stale values are never mistaken for data; req_read keeps its value.
  task automatic send(input logic [6:0] a, input logic rd, input logic [7:0] c, pg, pc, d);
    @(negedge sys_clk);
    {req_valid, req_addr, req_read, req_code} = {1'b1, a, rd, c};
    {req_pp_page, req_pp_code, req_wdata} = {pg, pc, d};
    @(negedge sys_clk);
    {req_valid, req_addr, req_code, req_wdata} = {1'b0, ~a, ~c, ~d};
    {req_pp_page, req_pp_code} = {~pg, ~pc};
  endtask : send
endmodule : ppa_host

// ### sim/ppa_top_tb_top.sv
/*
 * Self-checking bench for the paging, write-lock and addressing command layer.
 * Assumes the host model drives requests and answers stand when send returns.
 */
`timescale 1ns/1ps

module ppa_top_tb_top;
  import ppa_pkg::*;
  localparam logic [6:0] GA = 7'h5a;
  localparam logic [7:0] RC [6] = '{8'h00, 8'h10, 8'hd0, 8'hd1, 8'he6, 8'hfa};
  localparam logic [7:0] RV [6] = '{8'h00, 8'h00, 8'h1d, 8'h21, 8'h4f, 8'h80};
  localparam logic [7:0] PG [3] = '{8'h00, 8'h01, 8'hff};
  localparam logic [7:0] LK [4] = '{8'h00, 8'h20, 8'h40, 8'h80};
  localparam logic [7:0] CM [9] = '{8'h01, 8'h02, 8'h03, 8'h15, 8'h21, 8'h78, 8'hbd, 8'hd1, 8'he3};
  logic sys_clk = 0, rst = 1, nv_load = 0, wp_pin = 0, rail_contention = 0;
  logic [7:0] nv_write_lock = 8'h00, nv_chan_cfg0 = 8'h1d, nv_chan_cfg1 = 8'h1d;
  logic [7:0] nv_global_cfg = 8'h21, nv_dev_addr = 8'h4f, nv_rail0 = 8'h80, nv_rail1 = 8'h80;
  logic [7:0] ext_rdata0 = 8'h3c, ext_rdata1 = 8'hc3;
  logic addr_select_low_open = 1, addr_select_high_open = 1;
  logic [3:0] addr_select_low_val = 0;
  logic [2:0] addr_select_high_val = 0;
  logic req_valid, req_read, rsp_valid, rsp_ack, cml_fault, wp_status;
  logic [6:0] req_addr, effective_addr;
  logic [7:0] req_code, req_pp_page, req_pp_code, req_wdata, rsp_rdata, fwd_code, fwd_data;
  logic [7:0] page_out, global_cfg_out, d, gexp;
  logic [1:0] fwd_wr_en, fwd_rd_sel;
  logic [6:0] na;
  logic a;
  int fails = 0, num_checks = 0, cyc = 0;

  ppa_top DUT (.*);
  ppa_host host (.*);

  initial forever #25 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rsp(input logic ack, flt);
    num_checks++;
    if ({rsp_valid, rsp_ack, cml_fault} !== {1'b1, ack, flt}) begin
      fails++;
      $display("[ERR] %0t answer %b%b%b", $time, rsp_valid, rsp_ack, cml_fault);
    end
  endtask : chk_rsp

  task automatic wr(input logic [7:0] c, dd);
    host.send(GA, 1'b0, c, 8'h00, 8'h00, dd);
  endtask : wr

  function automatic logic allowed(input logic [7:0] lk, input logic wp, input logic [7:0] c);
    logic base;
    logic mid;
    base = c inside {8'h00, 8'h10, 8'hbd};
    mid = c inside {8'h01, 8'h03, 8'he3, [8'h78:8'h80]};
    if (wp) return base || mid;
    case (lk)
      8'h80: return base || c == 8'h15;
      8'h40: return base || mid || c == 8'h15;
      8'h20: return base || mid || c inside {8'h02, 8'h15, 8'h21};
      default: return 1'b1;
    endcase
  endfunction : allowed

  initial begin
    d = $urandom(79369);
    repeat (2) @(negedge sys_clk);
    rst = 0;
    // ************************************************************************
    // Reset values, paging and page-plus
    // ************************************************************************
    foreach (RC[i]) begin
      host.send(GA, 1'b1, RC[i], 8'h00, 8'h00, 8'h00);
      chk(rsp_rdata, RV[i]);
    end
    foreach (PG[i]) begin
      wr(8'h00, PG[i]);
      d = $urandom;
      wr(8'h21, d);
      chk({6'h0, fwd_wr_en}, PG[i] == 8'h00 ? 8'h01 : PG[i] == 8'h01 ? 8'h02 : 8'h03);
      chk(fwd_data, d);
      chk(fwd_code, 8'h21);
    end
    wr(8'h00, 8'h02);
    chk(page_out, 8'hff);
    wr(8'h00, 8'h00);
    d = $urandom;
    host.send(GA, 1'b0, 8'h05, 8'h01, 8'hd0, d);
    chk_rsp(1'b1, 1'b0);
    host.send(GA, 1'b1, 8'h06, 8'h01, 8'hd0, 8'h00);
    chk(rsp_rdata, d);
    host.send(GA, 1'b1, 8'h06, 8'h00, 8'hd0, 8'h00);
    chk(rsp_rdata, 8'h1d);
    host.send(GA, 1'b1, 8'h06, 8'h01, 8'h21, 8'h00);
    chk(rsp_rdata, 8'hc3);
    host.send(GA, 1'b1, 8'h21, 8'h00, 8'h00, 8'h00);
    chk(rsp_rdata, 8'h3c);
    host.send(GA, 1'b0, 8'h05, 8'h07, 8'hd1, 8'h21);
    chk_rsp(1'b1, 1'b0);
    host.send(GA, 1'b0, 8'h05, 8'h00, 8'h06, 8'h00);
    chk_rsp(1'b0, 1'b1);
    host.send(GA, 1'b1, 8'h06, 8'h00, 8'h05, 8'h00);
    chk_rsp(1'b0, 1'b1);
    // ************************************************************************
    // Write-lock levels and protect pin
    // ************************************************************************
    gexp = 8'h21;
    for (int i = 0; i < 5; i++) begin
      wr(8'h10, i < 4 ? LK[i] : 8'h00);
      wp_pin = (i == 4);
      foreach (CM[j]) begin
        d = $urandom;
        wr(CM[j], d);
        a = allowed(i < 4 ? LK[i] : 8'h00, wp_pin, CM[j]);
        chk_rsp(a, !a);
        if (a && CM[j] == 8'hd1) gexp = d;
        chk(global_cfg_out, gexp);
      end
      host.send(GA, 1'b0, 8'h05, 8'h00, 8'h01, 8'h40);
      a = allowed(i < 4 ? LK[i] : 8'h00, wp_pin, 8'h01);
      chk_rsp(a, !a);
      host.send(GA, 1'b1, 8'h10, 8'h00, 8'h00, 8'h00);
      chk(rsp_rdata, i < 4 ? LK[i] : 8'h00);
    end
    wp_pin = 0;
    // ************************************************************************
    // Addressing
    // ************************************************************************
    na = 7'($urandom_range(8'h4f, 8'h10));
    {nv_dev_addr, nv_global_cfg, nv_load} = {1'b0, na, gexp, 1'b1};
    @(negedge sys_clk);
    nv_load = 0;
    @(negedge sys_clk);
    chk({1'b0, effective_addr}, {1'b0, na});
    for (int k = 1; k < 4; k++) begin
      {addr_select_high_open, addr_select_low_open} = ~2'(k);
      {addr_select_high_val, addr_select_low_val} = 7'($urandom);
      #1;
      chk({1'b0, effective_addr}, {1'b0, k[1] ? addr_select_high_val : na[6:4],
        k[0] ? addr_select_low_val : na[3:0]});
    end
    {addr_select_high_open, addr_select_low_open} = 2'b11;
    host.send(na, 1'b1, 8'h10, 8'h00, 8'h00, 8'h00);
    chk_rsp(1'b1, 1'b0);
    wr(8'he6, 8'h80);
    host.send(na, 1'b1, 8'h10, 8'h00, 8'h00, 8'h00);
    chk_rsp(1'b0, 1'b0);
    host.send(7'h5b, 1'b1, 8'h10, 8'h00, 8'h00, 8'h00);
    chk_rsp(1'b1, 1'b0);
    wr(8'hfa, 8'h33);
    host.send(7'h33, 1'b0, 8'h21, 8'h00, 8'h00, d);
    chk({6'h0, fwd_wr_en}, 8'h01);
    host.send(7'h33, 1'b1, 8'h21, 8'h00, 8'h00, 8'h00);
    rail_contention = 1;
    @(negedge sys_clk);
    rail_contention = 0;
    chk({7'h0, cml_fault}, 8'h01);
    wr(8'hfa, 8'h80);
    host.send(7'h33, 1'b0, 8'h21, 8'h00, 8'h00, d);
    chk_rsp(1'b0, 1'b0);
    stop_test();
  end
endmodule : ppa_top_tb_top
